// ---- design/pin_waveform_timing_params.svh ----
`ifndef PIN_WAVEFORM_TIMING_PARAMS_SVH
`define PIN_WAVEFORM_TIMING_PARAMS_SVH
`define ADDR_CHAN1_SECOND_SUBPERIOD 16'h1082
`define ADDR_CHAN0_SECOND_SUBPERIOD 16'h1083
`define ADDR_CHAN1_THIRD_SUBPERIOD 16'h1084
`define ADDR_CHAN0_THIRD_SUBPERIOD 16'h1085
`define ADDR_CHAN1_FOURTH_SUBPERIOD 16'h1086
`define ADDR_CHAN0_FOURTH_SUBPERIOD 16'h1087
`define ADDR_CHAN1_FIFTH_SUBPERIOD 16'h1088
`define ADDR_CHAN0_FIFTH_SUBPERIOD 16'h1089
`define ADDR_CHAN1_PERIOD_COUNT 16'h108a
`define ADDR_CHAN0_PERIOD_COUNT 16'h108b
`define ADDR_CHAN3_FIRST_SUBPERIOD 16'h108c
`define ADDR_CHAN2_FIRST_SUBPERIOD 16'h108d
`define ADDR_CHAN3_SECOND_SUBPERIOD 16'h108e
`define ADDR_CHAN2_SECOND_SUBPERIOD 16'h108f
`define SUB_SLOTS 12
`define SUB_INDEX_W 4
`define SUB_LOW_GROUP_LAST 16'h0007
`define SUB_HIGH_GROUP_BASE 16'h000a
`define SUB_HIGH_GROUP_SHIFT 16'h0002
`define BYTE_RESET 8'h00
`define LEN_RESET 16'h0000
`define COUNT_ZERO 16'h0000
`define COUNT_ONE 16'h0001
`define UNMAPPED_READ 8'h00
`endif

// ---- design/pin_waveform_timing_pkg.sv ----
package pin_waveform_timing_pkg;
  typedef logic [15:0] len_t;
  typedef logic [7:0] byte_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    byte_t data;
  } reg_req_t;

  typedef struct packed {
    len_t c0_second;
    len_t c0_third;
    len_t c0_fourth;
    len_t c0_fifth;
    len_t c1_second;
    len_t c1_third;
    len_t c1_fourth;
    len_t c1_fifth;
    len_t c2_first;
    len_t c2_second;
    len_t c3_first;
    len_t c3_second;
  } sub_len_t;
endpackage

// ---- design/period_pair_counter.sv ----
`include "pin_waveform_timing_params.svh"
module period_pair_counter (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Configuration
  input wire logic i_mode16,
  input wire logic i_wr_hi,
  input wire logic i_wr_lo,
  input wire pin_waveform_timing_pkg::byte_t i_wdata,
  // Period end pulses, bit 0 for the low pin, bit 1 for the high pin
  input wire logic [1:0] i_done,
  // State
  output logic [15:0] o_remain,
  output logic [1:0] o_run
);
  logic [7:0] cnt_lo_reg;
  logic [7:0] cnt_hi_reg;
  logic [1:0] inf_reg;
  logic [1:0] run_reg;
  logic [7:0] cnt_lo_next;
  logic [7:0] cnt_hi_next;
  logic [1:0] inf_next;
  logic [1:0] run_next;
  logic [15:0] wide_dec;
  logic [15:0] wide_new;

  assign wide_dec = {cnt_hi_reg, cnt_lo_reg} - `COUNT_ONE;
  assign wide_new = {i_wr_hi ? i_wdata : cnt_hi_reg, i_wr_lo ? i_wdata : cnt_lo_reg};

  // A write takes priority over a period end in the same cycle, since it reconfigures the run.
  always_comb begin
    cnt_lo_next = cnt_lo_reg;
    cnt_hi_next = cnt_hi_reg;
    inf_next = inf_reg;
    run_next = run_reg;
    if (i_mode16) begin
      run_next[1] = 1'b0;
      if (i_wr_hi || i_wr_lo) begin
        cnt_hi_next = wide_new[15:8];
        cnt_lo_next = wide_new[7:0];
        inf_next[0] = (wide_new == `COUNT_ZERO);
        run_next[0] = 1'b1;
      end else if (i_done[0] && run_reg[0] && !inf_reg[0]) begin
        cnt_hi_next = wide_dec[15:8];
        cnt_lo_next = wide_dec[7:0];
        run_next[0] = (wide_dec != `COUNT_ZERO);
      end
    end else begin
      if (i_wr_lo) begin
        cnt_lo_next = i_wdata;
        inf_next[0] = (i_wdata == `BYTE_RESET);
        run_next[0] = 1'b1;
      end else if (i_done[0] && run_reg[0] && !inf_reg[0]) begin
        cnt_lo_next = cnt_lo_reg - 8'h01;
        run_next[0] = (cnt_lo_reg != 8'h01);
      end
      if (i_wr_hi) begin
        cnt_hi_next = i_wdata;
        inf_next[1] = (i_wdata == `BYTE_RESET);
        run_next[1] = 1'b1;
      end else if (i_done[1] && run_reg[1] && !inf_reg[1]) begin
        cnt_hi_next = cnt_hi_reg - 8'h01;
        run_next[1] = (cnt_hi_reg != 8'h01);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_lo_reg <= `BYTE_RESET;
      cnt_hi_reg <= `BYTE_RESET;
      inf_reg <= 2'h0;
      run_reg <= 2'h0;
    end else begin
      cnt_lo_reg <= cnt_lo_next;
      cnt_hi_reg <= cnt_hi_next;
      inf_reg <= inf_next;
      run_reg <= run_next;
    end
  end

  assign o_remain = {cnt_hi_reg, cnt_lo_reg};
  assign o_run = run_reg;
endmodule

// ---- design/pin_waveform_timing_regs.sv ----
`include "pin_waveform_timing_params.svh"
module pin_waveform_timing_regs (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register access
  input wire pin_waveform_timing_pkg::reg_req_t i_req,
  output pin_waveform_timing_pkg::byte_t o_rd_data,
  output logic o_rd_valid,
  // Mode and waveform sequencer interface
  input wire logic i_mode16,
  input wire logic [1:0] i_period_done,
  output pin_waveform_timing_pkg::sub_len_t o_sub_len,
  output logic [1:0] o_run
);
  localparam logic [15:0] BASE = `ADDR_CHAN1_SECOND_SUBPERIOD;

  logic [7:0] sub_reg [0:`SUB_SLOTS-1];
  pin_waveform_timing_pkg::sub_len_t len_reg;
  pin_waveform_timing_pkg::sub_len_t len_next;
  pin_waveform_timing_pkg::byte_t rd_data_reg;
  pin_waveform_timing_pkg::byte_t rd_data_next;
  logic rd_valid_reg;
  logic [7:0] snap_reg;
  logic snap_vld_reg;
  logic [15:0] remain;
  logic [1:0] run;

  // Maps an address onto a subperiod slot; even slots are the upper-byte registers.
  function automatic logic [`SUB_INDEX_W-1:0] sub_index(input logic [15:0] addr);
    logic [15:0] off;
    off = addr - BASE;
    if (off <= `SUB_LOW_GROUP_LAST) begin
      sub_index = off[`SUB_INDEX_W-1:0];
    end else begin
      sub_index = 4'(off - `SUB_HIGH_GROUP_SHIFT);
    end
  endfunction

  function automatic logic is_sub(input logic [15:0] addr);
    logic [15:0] off;
    off = addr - BASE;
    is_sub = (addr >= BASE) &&
             ((off <= `SUB_LOW_GROUP_LAST) ||
              ((off >= `SUB_HIGH_GROUP_BASE) && (addr <= `ADDR_CHAN2_SECOND_SUBPERIOD)));
  endfunction

  // Length of a low pin: alone in 8-bit mode, joined with its partner in 16-bit mode.
  function automatic pin_waveform_timing_pkg::len_t lo_len(input logic [7:0] hi,
                                                          input logic [7:0] lo,
                                                          input logic m16);
    lo_len = m16 ? {hi, lo} : {8'h00, lo};
  endfunction

  // The high pin has no waveform of its own once its register lends the upper byte.
  function automatic pin_waveform_timing_pkg::len_t hi_len(input logic [7:0] hi,
                                                          input logic m16);
    hi_len = m16 ? `LEN_RESET : {8'h00, hi};
  endfunction

  wire wr_sub = i_req.wr && is_sub(i_req.addr);
  wire [`SUB_INDEX_W-1:0] wr_idx = sub_index(i_req.addr);
  wire wr_cnt_hi = i_req.wr && (i_req.addr == `ADDR_CHAN1_PERIOD_COUNT);
  wire wr_cnt_lo = i_req.wr && (i_req.addr == `ADDR_CHAN0_PERIOD_COUNT);
  wire rd_sub = i_req.rd && is_sub(i_req.addr);
  wire rd_cnt_hi = i_req.rd && (i_req.addr == `ADDR_CHAN1_PERIOD_COUNT);
  wire rd_cnt_lo = i_req.rd && (i_req.addr == `ADDR_CHAN0_PERIOD_COUNT);
  wire use_snap = i_mode16 && snap_vld_reg;

  period_pair_counter u_count (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_mode16(i_mode16),
    .i_wr_hi(wr_cnt_hi),
    .i_wr_lo(wr_cnt_lo),
    .i_wdata(i_req.data),
    .i_done(i_period_done),
    .o_remain(remain),
    .o_run(run)
  );

  always_comb begin
    len_next.c0_second = lo_len(sub_reg[0], sub_reg[1], i_mode16);
    len_next.c0_third = lo_len(sub_reg[2], sub_reg[3], i_mode16);
    len_next.c0_fourth = lo_len(sub_reg[4], sub_reg[5], i_mode16);
    len_next.c0_fifth = lo_len(sub_reg[6], sub_reg[7], i_mode16);
    len_next.c1_second = hi_len(sub_reg[0], i_mode16);
    len_next.c1_third = hi_len(sub_reg[2], i_mode16);
    len_next.c1_fourth = hi_len(sub_reg[4], i_mode16);
    len_next.c1_fifth = hi_len(sub_reg[6], i_mode16);
    len_next.c2_first = lo_len(sub_reg[8], sub_reg[9], i_mode16);
    len_next.c2_second = lo_len(sub_reg[10], sub_reg[11], i_mode16);
    len_next.c3_first = hi_len(sub_reg[8], i_mode16);
    len_next.c3_second = hi_len(sub_reg[10], i_mode16);
  end

  // Duration reads show the live count, except a 16-bit low-byte read after an upper-byte read returns the byte captured then.
  always_comb begin
    rd_data_next = `UNMAPPED_READ;
    if (rd_sub) begin
      rd_data_next = sub_reg[sub_index(i_req.addr)];
    end else if (rd_cnt_hi) begin
      rd_data_next = remain[15:8];
    end else if (rd_cnt_lo) begin
      rd_data_next = use_snap ? snap_reg : remain[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int k = 0; k < `SUB_SLOTS; k++) begin
        sub_reg[k] <= `BYTE_RESET;
      end
    end else if (wr_sub) begin
      sub_reg[wr_idx] <= i_req.data;
    end
  end

  // A fresh duration write discards a pending capture so a stale byte is never returned.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      snap_reg <= `BYTE_RESET;
      snap_vld_reg <= 1'b0;
    end else if (wr_cnt_hi || wr_cnt_lo) begin
      snap_vld_reg <= 1'b0;
    end else if (rd_cnt_hi && i_mode16) begin
      snap_reg <= remain[7:0];
      snap_vld_reg <= 1'b1;
    end else if (rd_cnt_lo) begin
      snap_vld_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      len_reg <= '0;
      rd_data_reg <= `BYTE_RESET;
      rd_valid_reg <= 1'b0;
    end else begin
      len_reg <= len_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= i_req.rd;
    end
  end

  assign o_sub_len = len_reg;
  assign o_rd_data = rd_data_reg;
  assign o_rd_valid = rd_valid_reg;
  assign o_run = run;
endmodule

// ---- dv/pin_waveform_timing_checker.sv ----
module pin_waveform_timing_checker (
  // Clock, reset and requests
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire pin_waveform_timing_pkg::reg_req_t i_req,
  input wire logic i_mode16,
  input wire logic [1:0] i_period_done,
  // Block outputs
  input wire pin_waveform_timing_pkg::byte_t o_rd_data,
  input wire logic o_rd_valid,
  input wire pin_waveform_timing_pkg::sub_len_t o_sub_len,
  input wire logic [1:0] o_run
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire wr_lo = i_req.wr && i_req.addr == 16'h108b;
  wire rd_hi = i_req.rd && !i_req.wr && i_req.addr == 16'h108a;
  low_byte_a: assert property (i_req.wr && i_req.addr == 16'h1083 |=> ##1
    o_sub_len.c0_second[7:0] == $past(i_req.data, 2)) else $error("low byte");
  narrow_mode_a: assert property (!i_mode16 && $past(!i_mode16) |->
    o_sub_len.c0_second[15:8] == 8'h00) else $error("upper byte set");
  pair_low_a: assert property (i_mode16 && i_req.wr && i_req.addr == 16'h1082
    ##1 i_mode16 |=> o_sub_len.c0_second[15:8] == $past(i_req.data, 2)) else $error("pair 0");
  pair_high_a: assert property (i_mode16 && i_req.wr && i_req.addr == 16'h108e
    ##1 i_mode16 |=> o_sub_len.c2_second[15:8] == $past(i_req.data, 2)) else $error("pair 2");
  run_start_a: assert property (wr_lo |=> o_run[0]) else $error("no run");
  run_stop_a: assert property (wr_lo && i_req.data == 8'h01 && !i_mode16 ##1 !i_req.wr
    ##1 i_period_done[0] && !i_req.wr |=> !o_run[0]) else $error("no stop");
  endless_run_a: assert property (wr_lo && i_req.data == 8'h00 && !i_mode16
    ##1 (!i_req.wr && !i_mode16) [*3] |=> o_run[0]) else $error("run ended");
  idle_read_a: assert property (i_req.rd && !i_req.wr && i_req.addr == 16'h108b
    && !i_mode16 && !o_run[0] |=> o_rd_valid && o_rd_data == 8'h00) else $error("idle");
  upper_read_a: assert property (i_mode16 && i_req.wr && i_req.addr == 16'h108a
    ##1 i_mode16 && !i_period_done[0] && !i_req.wr ##1 i_mode16 && rd_hi
    && !i_period_done[0] |=> o_rd_data == $past(i_req.data, 3)) else $error("upper");
  cover property (o_rd_valid);
  cover property ($fell(o_run[0]));
  cover property (i_mode16 && rd_hi);
endmodule

bind pin_waveform_timing_regs pin_waveform_timing_checker u_chk (.i_clk, .i_rst_n, .i_req,
  .i_mode16, .i_period_done, .o_rd_data, .o_rd_valid, .o_sub_len, .o_run);

// ---- dv/pin_waveform_timing_regs_tb.sv ----
module pin_waveform_timing_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_mode16 = 1'b0;
  logic [1:0] i_period_done = 2'h0;
  pin_waveform_timing_pkg::reg_req_t i_req = '0;
  pin_waveform_timing_pkg::byte_t o_rd_data;
  logic o_rd_valid;
  pin_waveform_timing_pkg::sub_len_t o_sub_len;
  logic [1:0] o_run;
  pin_waveform_timing_pkg::byte_t d [16];
  logic [7:0] exp_q [$];
  logic [15:0] seed = 16'h1f79;
  int bad_count = 0;
  int checks = 0;
  always #2.5 i_clk = ~i_clk;
  pin_waveform_timing_regs u_dut (.i_clk, .i_rst_n, .i_req, .o_rd_data, .o_rd_valid,
    .i_mode16, .i_period_done, .o_sub_len, .o_run);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge i_clk) i_req <= {1'b1, 1'b0, a, v};
    @(negedge i_clk) i_req <= '0;
  endtask
  // The expectation is queued before the strobe so the monitor always finds it.
  task automatic rd(input logic [15:0] a, input logic [7:0] v);
    exp_q.push_back(v);
    @(negedge i_clk) i_req <= {1'b0, 1'b1, a, 8'h00};
    @(negedge i_clk) i_req <= '0;
  endtask
  task automatic pulse(input logic [1:0] b);
    @(negedge i_clk) i_period_done <= b;
    @(negedge i_clk) i_period_done <= 2'h0;
  endtask
  task automatic stop_test();
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(negedge i_clk) begin
    if (o_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(16'h0001, 16'h0000);
      else chk({8'h00, o_rd_data}, {8'h00, exp_q.pop_front()});
    end
  end
  initial begin
    #500000;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (20) @(negedge i_clk);
    i_rst_n <= 1'b1;
    for (int a = 16'h1081; a < 16'h1090; a++) rd(16'(a), 8'h00);
    for (int m = 0; m < 2; m++) begin
      @(negedge i_clk) i_mode16 <= m[0];
      for (int i = 2; i < 16; i++) begin
        seed = lfsr(seed);
        d[i] = seed[7:0];
        if (i < 10 || i > 11) wr(16'h1080 + 16'(i), d[i]);
      end
      @(negedge i_clk);
      chk(o_sub_len.c0_second, m ? {d[2], d[3]} : {8'h00, d[3]});
      chk(o_sub_len.c0_fifth, m ? {d[8], d[9]} : {8'h00, d[9]});
      chk(o_sub_len.c2_second, m ? {d[14], d[15]} : {8'h00, d[15]});
      chk(o_sub_len.c1_second, m ? 16'h0000 : {8'h00, d[2]});
      chk(o_sub_len.c3_first, m ? 16'h0000 : {8'h00, d[12]});
      chk(o_sub_len.c0_third, m ? {d[4], d[5]} : {8'h00, d[5]});
      chk(o_sub_len.c0_fourth, m ? {d[6], d[7]} : {8'h00, d[7]});
      chk(o_sub_len.c2_first, m ? {d[12], d[13]} : {8'h00, d[13]});
      chk(o_sub_len.c1_third, m ? 16'h0000 : {8'h00, d[4]});
      chk(o_sub_len.c1_fourth, m ? 16'h0000 : {8'h00, d[6]});
      chk(o_sub_len.c1_fifth, m ? 16'h0000 : {8'h00, d[8]});
      chk(o_sub_len.c3_second, m ? 16'h0000 : {8'h00, d[14]});
      for (int i = 2; i < 16; i++) if (i < 10 || i > 11) rd(16'h1080 + 16'(i), d[i]);
    end
    @(negedge i_clk) i_mode16 <= 1'b0;
    wr(16'h108b, 8'h03);
    chk(o_run[0], 1'b1);
    rd(16'h108b, 8'h03);
    pulse(2'h1);
    pulse(2'h1);
    rd(16'h108b, 8'h01);
    pulse(2'h1);
    chk(o_run[0], 1'b0);
    rd(16'h108b, 8'h00);
    wr(16'h108b, 8'h01);
    pulse(2'h1);
    chk(o_run[0], 1'b0);
    wr(16'h108a, 8'h01);
    pulse(2'h2);
    chk(o_run[1], 1'b0);
    wr(16'h108b, 8'h00);
    repeat (4) pulse(2'h1);
    chk(o_run[0], 1'b1);
    @(negedge i_clk) i_mode16 <= 1'b1;
    wr(16'h108b, 8'h00);
    wr(16'h108a, 8'h01);
    chk(o_run[1], 1'b0);
    chk(o_run[0], 1'b1);
    rd(16'h108a, 8'h01);
    pulse(2'h1);
    rd(16'h108b, 8'h00);
    rd(16'h108a, 8'h00);
    rd(16'h108b, 8'hff);
    for (int k = 0; k < 8 && exp_q.size() > 0; k++) @(negedge i_clk);
    if (exp_q.size() > 0) bad_count++;
    stop_test();
  end
endmodule
